// [verilog/fog_pkg.sv]
// Package: register map, field layout and timing of the fail output and pin function block
package fog_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] DEVICE_STATUS_OFS  = 8'h04;
   localparam logic [7:0] WAKE_STAT_OFS = 8'h08;
   localparam logic [7:0] PWM_OFS       = 8'h0C;
   localparam logic [7:0] LEVEL_OFS     = 8'h10;
   // Control register fields
   localparam int CTRL_FUNC_LSB  = 0;
   localparam int CTRL_FORCE_BIT = 3;
   localparam int CTRL_LOCK_BIT  = 4;
   localparam int CTRL_PULL_LSB  = 5;
   localparam int CTRL_OVR_BIT   = 7;
   // Status register fields
   localparam int STAT_FAIL_BIT  = 0;
   localparam int STAT_WDF_BIT   = 1;
   localparam int STAT_OC_BIT    = 2;
   // Pin function codes
   localparam logic [2:0] FUNC_OFF  = 3'h4;
   localparam logic [2:0] FUNC_WAKE = 3'h5;
   localparam logic [2:0] FUNC_LS   = 3'h6;
   localparam logic [2:0] FUNC_HS   = 3'h7;
   localparam logic [2:0] FUNC_RST  = 3'h0;
   localparam logic [1:0] PULL_RST  = 2'h0;
   // Device modes
   typedef enum logic [2:0]
   {
      MODE_NORMAL   = 3'h0,
      MODE_STOP     = 3'h1,
      MODE_SLEEP    = 3'h2,
      MODE_RESTART  = 3'h3,
      MODE_FAILSAFE = 3'h4
   } fog_mode_t;
   // Timing at 10 MHz
   localparam int CLK_NS         = 100;
   localparam int FILTER_NS      = 16000;
   localparam int FILTER_CYC     = FILTER_NS / CLK_NS;
   localparam int BLANK_NS       = 10000;
   localparam int BLANK_CYC      = BLANK_NS / CLK_NS;
   localparam int INT_PULSE_NS   = 100000;
   localparam int INT_PULSE_CYC  = INT_PULSE_NS / CLK_NS;
endpackage : fog_pkg

// [verilog/fog_top.sv]
// Fail output and multi-purpose pin function logic with APB registers
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module fog_top #(
   parameter int PWM_W = 8
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [2:0]       dev_mode,
   input  wire logic             watchdog_failure_indication_event,
   input  wire logic             wd_trigger_ok,
   input  wire logic             wd_disabled,
   input  wire logic             wd_second_fail_cfg,
   input  wire logic             wd_failsafe_cfg,
   input  wire logic             thermal_shutdown_level_two,
   input  wire logic             regulator_short,
   input  wire logic             regulator_overvoltage,
   input  wire logic             pin_in,
   input  wire logic             overcurrent_in,
   output logic                  pin_out,
   output logic                  pin_oe_n,
   output logic                  pull_up_en,
   output logic                  pull_down_en,
   output logic                  hs_switch_on,
   output logic                  failsafe_req,
   output logic                  wake_req,
   output logic                  intn
);
   // All block state in one record
   typedef struct packed {
      logic [2:0]       func;
      logic             force_on;
      logic             lock;
      logic [1:0]       pull;
      logic             ovr_en;
      logic             failure;
      logic             watchdog_failure_indication;
      logic             wd_first;
      logic             wd_caused;
      logic             fo_latched;
      logic             oc_flag;
      logic             wake_flag;
      logic             level;
      logic             level_vis;
      logic             filt_ref;
      logic [7:0]       blank_cnt;
      logic [7:0]       filt_cnt;
      logic [PWM_W-1:0] duty;
      logic [PWM_W-1:0] period;
      logic [PWM_W-1:0] pwm_cnt;
      logic [3:0]       freq_div;
      logic [3:0]       div_cnt;
      logic [10:0]      int_cnt;
      logic [2:0]       mode_q;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic             pin_oe_n;
      logic             pull_up;
      logic             pull_down;
      logic             hs_on;
      logic             failsafe;
      logic             wake;
      logic             intn;
   } fog_state_t;

   fog_state_t st_r;
   fog_state_t st_nxt;

   // Fail-output role decode for codes 000 to 010
   function automatic logic is_fo_role(input logic [2:0] f);
      is_fo_role = (f <= 3'h2);
   endfunction : is_fo_role

   logic wr_acc;
   logic wake_role;
   logic fail_cond;
   logic wd_hit;
   logic pwm_on;
   logic [2:0] new_func;
   assign wr_acc    = psel && penable && pwrite && !st_r.pready;
   assign wake_role = (st_r.func == fog_pkg::FUNC_WAKE);

   // Next-state logic
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.mode_q  = dev_mode;
      new_func       = pwdata[fog_pkg::CTRL_FUNC_LSB +: 3];
      wd_hit = watchdog_failure_indication_event && (!wd_second_fail_cfg || st_r.wd_first);
      if (watchdog_failure_indication_event)
         st_nxt.wd_first = 1'b1;
      fail_cond = thermal_shutdown_level_two || regulator_short
                  || (regulator_overvoltage && st_r.ovr_en);
      if (wd_trigger_ok)
      begin
         st_nxt.watchdog_failure_indication  = 1'b0;
         st_nxt.wd_first = 1'b0;
      end
      // watchdog failure cleared on sleep, other-fail fail-safe, stop with wd off
      if ((dev_mode == fog_pkg::MODE_SLEEP && st_r.mode_q != fog_pkg::MODE_SLEEP)
          || (fail_cond && !wd_hit)
          || (dev_mode == fog_pkg::MODE_STOP && wd_disabled))
      begin
         st_nxt.watchdog_failure_indication  = 1'b0;
         st_nxt.wd_first = 1'b0;
      end
      if (wd_hit)
      begin
         st_nxt.watchdog_failure_indication   = 1'b1;
         st_nxt.wd_caused = 1'b1;
      end
      st_nxt.failsafe = fail_cond || (wd_hit && wd_failsafe_cfg);
      // APB register access, one wait state
      st_nxt.prdata = 32'h0000_0000;
      if (psel && penable && !st_r.pready)
      begin
         st_nxt.pready = 1'b1;
         case (paddr)
            fog_pkg::CTRL_OFS:
            begin
               if (pwrite)
               begin
                  if (!st_r.lock && dev_mode == fog_pkg::MODE_NORMAL)
                     st_nxt.func = new_func;
                  // force bit writable in every role
                  st_nxt.force_on = pwdata[fog_pkg::CTRL_FORCE_BIT];
                  st_nxt.lock   = pwdata[fog_pkg::CTRL_LOCK_BIT];
                  st_nxt.pull   = pwdata[fog_pkg::CTRL_PULL_LSB +: 2];
                  st_nxt.ovr_en = pwdata[fog_pkg::CTRL_OVR_BIT];
               end
               st_nxt.prdata = {24'h00_0000, st_r.ovr_en, st_r.pull, st_r.lock,
                                st_r.force_on, st_r.func};
            end
            fog_pkg::DEVICE_STATUS_OFS:
            begin
               // write one clears failure and overcurrent
               if (pwrite && pwdata[fog_pkg::STAT_FAIL_BIT])
                  st_nxt.failure = 1'b0;
               if (pwrite && pwdata[fog_pkg::STAT_OC_BIT])
                  st_nxt.oc_flag = 1'b0;
               st_nxt.prdata = {29'h0000_0000, st_r.oc_flag, st_r.watchdog_failure_indication, st_r.failure};
            end
            fog_pkg::WAKE_STAT_OFS:
            begin
               if (pwrite && pwdata[0])
                  st_nxt.wake_flag = 1'b0;
               st_nxt.prdata = {31'h0000_0000, st_r.wake_flag};
            end
            fog_pkg::PWM_OFS:
            begin
               if (pwrite)
               begin
                  st_nxt.duty     = pwdata[PWM_W-1:0];
                  st_nxt.period   = pwdata[8 +: PWM_W];
                  st_nxt.freq_div = pwdata[16 +: 4];
               end
               st_nxt.prdata = {12'h000, st_r.freq_div, 8'h00, st_r.duty}
                               | ({24'h00_0000, st_r.period} << 8);
            end
            fog_pkg::LEVEL_OFS:
               // level visible only once normal again
               st_nxt.prdata = {31'h0000_0000, st_r.level_vis};
            default:
               st_nxt.pslverr = 1'b1;
         endcase
      end
      // failure activation sets status flag, set wins over clear
      if (fail_cond || wd_hit)
      begin
         st_nxt.failure    = 1'b1;
         st_nxt.fo_latched = 1'b1;
      end
      // release when failures gone and flag cleared
      // watchdog cause needs cleared failure indication
      if (st_r.fo_latched && !st_nxt.failure && !fail_cond
          && !(st_r.wd_caused && st_nxt.watchdog_failure_indication))
      begin
         st_nxt.fo_latched = 1'b0;
         st_nxt.wd_caused  = 1'b0;
      end
      if (dev_mode == fog_pkg::MODE_RESTART && st_r.mode_q != fog_pkg::MODE_RESTART)
         st_nxt.force_on = 1'b0;
      // Switch roles fall back to off on restart or fail-safe
      if ((dev_mode == fog_pkg::MODE_RESTART || dev_mode == fog_pkg::MODE_FAILSAFE)
          && (st_r.func == fog_pkg::FUNC_LS || st_r.func == fog_pkg::FUNC_HS))
         st_nxt.func = fog_pkg::FUNC_OFF;
      // modulator with prescaler, 0 off, duty above period on
      st_nxt.div_cnt = st_r.div_cnt + 4'h1;
      if (st_r.div_cnt >= st_r.freq_div)
      begin
         st_nxt.div_cnt = 4'h0;
         st_nxt.pwm_cnt = (st_r.pwm_cnt >= st_r.period) ? '0 : st_r.pwm_cnt + 1'b1;
      end
      pwm_on = (st_r.duty != '0) && (st_r.pwm_cnt < st_r.duty);
      // overcurrent sampled during on-time, switch shut down
      if ((st_r.func == fog_pkg::FUNC_LS || st_r.func == fog_pkg::FUNC_HS)
          && pwm_on && overcurrent_in)
      begin
         st_nxt.oc_flag = 1'b1;
         st_nxt.func    = fog_pkg::FUNC_OFF;
      end
      if (!wake_role)
      begin
         st_nxt.blank_cnt = 8'h00;
         st_nxt.filt_cnt  = 8'h00;
      end
      else if (st_r.blank_cnt < 8'(fog_pkg::BLANK_CYC))
         st_nxt.blank_cnt = st_r.blank_cnt + 8'h01;
      else if (pin_in == st_r.filt_ref)
         st_nxt.filt_cnt = 8'h00;
      else if (st_r.filt_cnt < 8'(fog_pkg::FILTER_CYC - 1))
         st_nxt.filt_cnt = st_r.filt_cnt + 8'h01;
      else
      begin
         // Qualified edge
         st_nxt.filt_cnt = 8'h00;
         st_nxt.filt_ref = pin_in;
         st_nxt.level    = pin_in;
         // event stored in second wake status
         st_nxt.wake_flag = 1'b1;
         if (dev_mode == fog_pkg::MODE_NORMAL || dev_mode == fog_pkg::MODE_STOP)
            st_nxt.int_cnt = 11'(fog_pkg::INT_PULSE_CYC);
         if (dev_mode == fog_pkg::MODE_SLEEP)
            st_nxt.wake = 1'b1;
      end
      if (dev_mode != fog_pkg::MODE_SLEEP)
         st_nxt.wake = 1'b0;
      if (st_r.int_cnt != 11'h000)
         st_nxt.int_cnt = st_r.int_cnt - 11'h001;
      st_nxt.intn = (st_nxt.int_cnt == 11'h000);
      if (dev_mode == fog_pkg::MODE_FAILSAFE && st_r.mode_q != fog_pkg::MODE_FAILSAFE)
         st_nxt.wake_flag = 1'b0;
      // status copy frozen outside normal mode
      if (dev_mode == fog_pkg::MODE_NORMAL)
         st_nxt.level_vis = st_r.level;
      // Pin drive per role
      // fail output open drain, active low
      st_nxt.pin_oe_n = 1'b1;
      st_nxt.hs_on    = 1'b0;
      if (is_fo_role(st_nxt.func))
         st_nxt.pin_oe_n = !(st_nxt.fo_latched || st_nxt.force_on);
      else if (st_nxt.func == fog_pkg::FUNC_LS)
         st_nxt.pin_oe_n = !pwm_on;
      else if (st_nxt.func == fog_pkg::FUNC_HS)
         st_nxt.hs_on = pwm_on;
      st_nxt.pull_up   = wake_role && st_r.pull[0];
      st_nxt.pull_down = wake_role && st_r.pull[1];
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r          <= '0;
         st_r.func     <= fog_pkg::FUNC_RST;
         st_r.pull     <= fog_pkg::PULL_RST;
         st_r.pin_oe_n <= 1'b1;
         st_r.intn     <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign prdata       = st_r.prdata;
   assign pready       = st_r.pready;
   assign pslverr      = st_r.pslverr;
   assign pin_out      = 1'b0;
   assign pin_oe_n     = st_r.pin_oe_n;
   assign pull_up_en   = st_r.pull_up;
   assign pull_down_en = st_r.pull_down;
   assign hs_switch_on = st_r.hs_on;
   assign failsafe_req = st_r.failsafe;
   assign wake_req     = st_r.wake;
   assign intn         = st_r.intn;

   // Checks
   // flag follows failure
   fail_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (thermal_shutdown_level_two || regulator_short) |=> st_r.failure)
      else $error("failure flag not set");
   // pin held low while latched in fo role
   fo_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.fo_latched && is_fo_role(st_r.func)) |=> !st_r.pin_oe_n || !st_r.fo_latched)
      else $error("fail output released early");
   lock_func_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.lock && wr_acc && paddr == fog_pkg::CTRL_OFS && !overcurrent_in
       && dev_mode == fog_pkg::MODE_NORMAL) |=> $stable(st_r.func))
      else $error("locked function changed");
   pull_role_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.pull_up || st_r.pull_down) |-> $past(wake_role))
      else $error("pull enabled outside wake role");
   ovr_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!st_r.failure && regulator_overvoltage && !st_r.ovr_en && !thermal_shutdown_level_two
       && !regulator_short && !watchdog_failure_indication_event) |=> !st_r.failure)
      else $error("overvoltage set failure while disabled");
   int_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(st_r.intn) |=> !st_r.intn [*8])
      else $error("interrupt pulse too short");
   force_role_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.func == fog_pkg::FUNC_OFF) |-> st_r.pin_oe_n || $past(st_r.func) != st_r.func)
      else $error("pin driven in off role");
   force_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
      (dev_mode == fog_pkg::MODE_RESTART && st_r.mode_q != fog_pkg::MODE_RESTART)
      |=> !st_r.force_on)
      else $error("force survived restart");
   // fail-safe request follows a present failure
   fs_req_a: assert property (@(posedge pclk) disable iff (!presetn)
      (thermal_shutdown_level_two || regulator_short) |=> st_r.failsafe)
      else $error("fail-safe request missing");
   // watchdog off in stop drops the watchdog failure
   wd_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (dev_mode == fog_pkg::MODE_STOP && wd_disabled && !watchdog_failure_indication_event) |=> !st_r.watchdog_failure_indication)
      else $error("watchdog failure kept in stop");
   // fail-safe entry drops the wake event
   wake_fs_a: assert property (@(posedge pclk) disable iff (!presetn)
      (dev_mode == fog_pkg::MODE_FAILSAFE && st_r.mode_q != fog_pkg::MODE_FAILSAFE)
      |=> !st_r.wake_flag)
      else $error("wake event kept at fail-safe entry");
endmodule : fog_top

// [tb/fog_pin_model.sv]
// Pin network model: open-drain wire, pulls, external source and load
`timescale 1ns/1ps
module fog_pin_model (
   input  wire logic pclk,
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   input  wire logic pull_up_en,
   input  wire logic pull_down_en,
   input  wire logic hs_switch_on,
   input  wire logic ext_en,
   input  wire logic ext_lvl,
   input  wire logic short_load,
   output logic      pin_in,
   output logic      overcurrent_in
);
   logic last_r = 1'b0;
   // open-drain wire level
   // Floating line shows the inverse of its last level, never a stale copy
   always_comb
   begin
      if (!pin_oe_n)
         pin_in = pin_out;
      else if (ext_en)
         pin_in = ext_lvl;
      else if (pull_up_en | pull_down_en)
         pin_in = pull_up_en;
      else
         pin_in = ~last_r;
   end
   // Last level of the wire
   always_ff @(posedge pclk)
      last_r <= pin_in;
   assign overcurrent_in = short_load & (~pin_oe_n | hs_switch_on);
endmodule : fog_pin_model

// [tb/fail_output_and_pin_function_logic_test.sv]
// Self-checking bench of the fail output and pin function block
`timescale 1ns/1ps
module fail_output_and_pin_function_logic_test;
   localparam logic [7:0] A_CT = fog_pkg::CTRL_OFS;
   localparam logic [7:0] A_ST = fog_pkg::DEVICE_STATUS_OFS;
   localparam logic [7:0] A_WK = fog_pkg::WAKE_STAT_OFS;
   localparam logic [7:0] A_PW = fog_pkg::PWM_OFS;
   localparam logic [7:0] A_LV = fog_pkg::LEVEL_OFS;
   typedef struct packed {logic [31:0] m; logic [31:0] d; logic e;} fog_note_t;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, pin_in, overcurrent_in, pin_out, pin_oe_n;
   logic [2:0]  dev_mode = 0;
   logic        watchdog_failure_indication_event = 0, wd_trigger_ok = 0, wd_second_fail_cfg = 0;
   logic        wd_disabled = 0, wd_failsafe_cfg = 0;
   logic        thermal_shutdown_level_two = 0, regulator_short = 0;
   logic        regulator_overvoltage = 0, ext_en = 0, ext_lvl = 0, short_load = 0;
   logic        pull_up_en, pull_down_en, hs_switch_on, failsafe_req, wake_req, intn;
   int          n_errors = 0, check_count = 0, seed = 95851;
   fog_note_t   exp_q[$];
   always #50 pclk = ~pclk;
   fog_top #(.PWM_W(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_mode(dev_mode),
      .watchdog_failure_indication_event(watchdog_failure_indication_event), .wd_trigger_ok(wd_trigger_ok),
      .wd_disabled(wd_disabled), .wd_second_fail_cfg(wd_second_fail_cfg),
      .wd_failsafe_cfg(wd_failsafe_cfg),
      .thermal_shutdown_level_two(thermal_shutdown_level_two),
      .regulator_short(regulator_short), .regulator_overvoltage(regulator_overvoltage),
      .pin_in(pin_in), .overcurrent_in(overcurrent_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
      .hs_switch_on(hs_switch_on), .failsafe_req(failsafe_req), .wake_req(wake_req),
      .intn(intn));
   fog_pin_model u_pin (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .hs_switch_on(hs_switch_on),
      .ext_en(ext_en), .ext_lvl(ext_lvl), .short_load(short_load), .pin_in(pin_in),
      .overcurrent_in(overcurrent_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // APB transfer; the note goes on the queue before the request
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
      int          i;
      logic [31:0] r;
      r = $random(seed);
      repeat (r[1:0]) @(posedge pclk);
      exp_q.push_back('{w ? 32'h0 : m, d, e});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      while (pready !== 1'b1 && i < 50)
      begin
         @(posedge pclk);
         i++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         n_errors++;
         wrap_up;
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      apb(1'b0, a, d, m, 1'b0);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic pulse(input int sel);
      @(posedge pclk);
      if (sel == 0)
         watchdog_failure_indication_event <= 1'b1;
      else
         wd_trigger_ok <= 1'b1;
      @(posedge pclk);
      watchdog_failure_indication_event <= 1'b0;
      wd_trigger_ok <= 1'b0;
   endtask : pulse
   task automatic set_fault(input int sel, input logic v);
      case (sel)
         0: thermal_shutdown_level_two <= v;
         1: regulator_short <= v;
         default: regulator_overvoltage <= v;
      endcase
   endtask : set_fault
   // Bounded wait on intn (sel 0) or wake_req (sel 1)
   task automatic wait_sig(input int sel, input logic v, input int lim, output int n);
      n = 0;
      while (((sel == 0) ? intn : wake_req) !== v)
      begin
         @(posedge pclk);
         n++;
         if (n > lim)
         begin
            n_errors++;
            wrap_up;
         end
      end
   endtask : wait_sig
   task automatic count_on(output int n);
      n = 0;
      repeat (40)
      begin
         @(posedge pclk);
         n += (pin_oe_n === 1'b0);
      end
   endtask : count_on
   // Read-back monitor: oldest note against each answer
   always @(posedge pclk)
   begin
      fog_note_t n;
      if (pready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(32'h1, 32'h0);
         else
         begin
            n = exp_q.pop_front();
            check({31'h0, pslverr}, {31'h0, n.e});
            check(prdata & n.m, n.d & n.m);
         end
      end
   end
   // Main sequence
   initial
   begin
      int n;
      int c;
      int k;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      check(pin_oe_n, 1'b1);
      rd(A_CT, 32'h0, 32'hFF);
      rd(A_ST, 32'h0, 32'h7);
      apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 8'h24, $random(seed), 32'h0, 1'b1);
      // Thermal, short, then overvoltage gated by its enable
      for (c = 0; c < 3; c++)
      begin
         set_fault(c, 1'b1);
         cyc(2);
         check(pin_oe_n, c == 2);
         if (c == 2)
            wr(A_CT, 32'h80);
         cyc(2);
         check(pin_oe_n, 1'b0);
         check(failsafe_req, 1'b1);
         wr(A_ST, 32'h1);
         rd(A_ST, 32'h1, 32'h1);
         set_fault(c, 1'b0);
         dev_mode <= fog_pkg::MODE_SLEEP;
         cyc(3);
         check(pin_oe_n, 1'b0);
         dev_mode <= fog_pkg::MODE_NORMAL;
         wr(A_ST, 32'h1);
         cyc(2);
         check(pin_oe_n, 1'b1);
      end
      wr(A_CT, 32'h0);
      // Watchdog: first failure counts, then only the second one
      for (c = 0; c < 2; c++)
      begin
         wd_second_fail_cfg <= c[0];
         wd_failsafe_cfg <= c[0];
         for (k = 0; k <= c; k++)
         begin
            cyc(2);
            check(pin_oe_n, 1'b1);
            pulse(0);
         end
         cyc(1);
         check(failsafe_req, c[0]);
         cyc(1);
         check(pin_oe_n, 1'b0);
         rd(A_ST, 32'h3, 32'h3);
         wr(A_ST, 32'h1);
         cyc(2);
         check(pin_oe_n, 1'b0);
         pulse(1);
         wr(A_ST, 32'h1);
         cyc(2);
         check(pin_oe_n, 1'b1);
      end
      // Watchdog switched off in stop mode drops the watchdog failure
      wd_second_fail_cfg <= 1'b0;
      pulse(0);
      dev_mode <= fog_pkg::MODE_STOP;
      wd_disabled <= 1'b1;
      cyc(2);
      dev_mode <= fog_pkg::MODE_NORMAL;
      wd_disabled <= 1'b0;
      rd(A_ST, 32'h1, 32'h3);
      wr(A_ST, 32'h1);
      cyc(2);
      check(pin_oe_n, 1'b1);
      // Test force across the fail output codes and the off role
      for (c = 0; c < 3; c++)
      begin
         wr(A_CT, 32'h8 | c);
         cyc(2);
         check(pin_oe_n, 1'b0);
      end
      wr(A_CT, 32'h0);
      cyc(2);
      check(pin_oe_n, 1'b1);
      wr(A_CT, 32'hC);
      cyc(2);
      check(pin_oe_n, 1'b1);
      rd(A_CT, 32'hC, 32'hF);
      wr(A_CT, 32'h8);
      dev_mode <= fog_pkg::MODE_RESTART;
      cyc(3);
      check(pin_oe_n, 1'b1);
      dev_mode <= fog_pkg::MODE_NORMAL;
      cyc(3);
      check(pin_oe_n, 1'b1);
      // Lock and mode both refuse a function change
      wr(A_CT, 32'h10);
      wr(A_CT, 32'h14);
      rd(A_CT, 32'h10, 32'h17);
      wr(A_CT, 32'h0);
      dev_mode <= fog_pkg::MODE_STOP;
      wr(A_CT, 32'h4);
      rd(A_CT, 32'h0, 32'h7);
      dev_mode <= fog_pkg::MODE_NORMAL;
      // Wake role: blanking, filter, interrupt, level and sleep wake
      ext_en <= 1'b1;
      ext_lvl <= 1'b0;
      wr(A_CT, 32'h25);
      cyc(1);
      check({pull_up_en, pull_down_en}, 2'b10);
      cyc(119);
      ext_lvl <= 1'b1;
      wait_sig(0, 1'b0, 400, n);
      check(n >= 155 && n <= 175, 1'b1);
      wait_sig(0, 1'b1, 1200, n);
      check(n >= 990 && n <= 1010, 1'b1);
      rd(A_WK, 32'h1, 32'h1);
      rd(A_LV, 32'h1, 32'h1);
      wr(A_WK, 32'h1);
      dev_mode <= fog_pkg::MODE_SLEEP;
      ext_lvl <= 1'b0;
      wait_sig(1, 1'b1, 400, n);
      check(intn, 1'b1);
      dev_mode <= fog_pkg::MODE_FAILSAFE;
      cyc(3);
      dev_mode <= fog_pkg::MODE_NORMAL;
      cyc(3);
      rd(A_WK, 32'h0, 32'h1);
      rd(A_LV, 32'h0, 32'h1);
      wr(A_CT, 32'h24);
      ext_lvl <= 1'b1;
      cyc(300);
      check({pull_up_en, intn}, 2'b01);
      // Low-side: duty zero, always on, then overcurrent shutdown
      ext_en <= 1'b0;
      wr(A_PW, 32'h1000);
      wr(A_CT, 32'h6);
      count_on(n);
      check(n, 32'd0);
      wr(A_PW, 32'h130A);
      cyc(40);
      count_on(n);
      check(n, 32'd20);
      wr(A_PW, 32'h10FF);
      cyc(40);
      count_on(n);
      check(n, 32'd40);
      short_load <= 1'b1;
      cyc(3);
      check(pin_oe_n, 1'b1);
      short_load <= 1'b0;
      rd(A_ST, 32'h4, 32'h4);
      rd(A_CT, 32'h4, 32'h7);
      wr(A_ST, 32'h4);
      rd(A_ST, 32'h0, 32'h4);
      wr(A_CT, 32'h7);
      cyc(3);
      check({hs_switch_on, pin_oe_n}, 2'b11);
      wrap_up;
   end
endmodule : fail_output_and_pin_function_logic_test
